// ---- core/rwi_pkg.sv ----
package rwi_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam logic [18:0] ADDR_IRQ_CTRL = 19'h7FFF6;
  localparam logic [18:0] ADDR_WDOG_CTRL = 19'h7FFF7;
  localparam logic [18:0] ADDR_OSC_CAL = 19'h7FFF8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAL_OSC_STOP_BIT = 7;
  localparam int CAL_FIELD_W = 6;
  localparam int WD_KICK_BIT = 7;
  localparam int WD_PERMIT_BIT = 6;
  localparam int WD_TIMEOUT_W = 6;
  localparam int IRQ_WIE_BIT = 7;
  localparam int IRQ_AIE_BIT = 6;
  localparam int IRQ_PFE_BIT = 5;
  localparam int IRQ_HL_BIT = 3;
  localparam int IRQ_PL_BIT = 2;
  localparam logic [7:0] IRQ_RSVD_MASK = 8'h13;
  localparam logic [7:0] IRQ_WRITE_MASK = 8'hEC;
  localparam int FLAG_WDOG = 0;
  localparam int FLAG_ALARM = 1;
  localparam int FLAG_PFAIL = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CAL_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [5:0] WD_TIMEOUT_RESET = 6'h00;
  localparam logic WD_PERMIT_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Timing: one watchdog tick is 31.25 ms of the 32 Hz count
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 31_250_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 23;

endpackage

// ---- core/rwi_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module rwi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  // First stage feeds only the second stage
  always_comb begin
    next_stage1 = clk_en_in ? async_in : stage1;
    next_stage2 = clk_en_in ? stage1 : stage2;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_out = stage2;

endmodule

`default_nettype wire

// ---- core/rwi_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - A watchdog timeout always sets the watchdog flag and drives the interrupt only while its enable is 1.
// - An alarm match always sets the alarm flag and drives the interrupt only while its enable is 1.
// - A power-fail trip always sets the power-fail flag and drives the interrupt only while its enable is 1.
// - Bits D4, D1 and D0 of the interrupt control register do nothing, read zero, and the host writes zero.
// - The watchdog timeout is the timeout field times 31.25 ms ticks of the 32 Hz count.
// - With the polarity bit at 1 the interrupt pin is driven high when active, else it is an open-drain low.
module rwi_ctrl
  import rwi_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  input wire logic chip_en_n_in,
  input wire logic write_en_n_in,
  input wire logic output_en_n_in,
  input wire logic alarm_match_in,
  input wire logic power_fail_in,
  input wire logic [2:0] flag_clear_in,
  output logic watchdog_flag_out,
  output logic alarm_flag_out,
  output logic power_fail_flag_out,
  output logic irq_out,
  output logic irq_oe_n_out,
  output logic oscillator_stop_bit_out,
  output logic [CAL_FIELD_W-1:0] calibration_out
);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    addr_hit = (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  localparam int PIN_W = ADDR_W + DATA_W + 4;
  logic [PIN_W-1:0] pins_sync;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic ce_s;
  logic we_s;
  logic oe_s;
  logic ce_n_s;
  logic we_n_s;
  logic oe_n_s;
  logic pfail_s;

  // Strobes pass the flops inverted so the cleared stages read as idle, with no false edge after reset
  rwi_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .async_in({addr_in, dq_in, !chip_en_n_in, !write_en_n_in, !output_en_n_in, power_fail_in}),
    .sync_out(pins_sync)
  );

  assign {addr_s, data_s, ce_s, we_s, oe_s, pfail_s} = pins_sync;
  assign ce_n_s = !ce_s;
  assign we_n_s = !we_s;
  assign oe_n_s = !oe_s;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic we_n_prev;
  logic pfail_prev;
  logic [7:0] osc_cal;
  logic [7:0] irq_ctrl;
  logic [WD_TIMEOUT_W-1:0] wd_timeout_field;
  logic wd_permit;
  logic [DATA_W-1:0] next_dq;
  logic next_dq_oe_n;
  logic [7:0] next_osc_cal;
  logic [7:0] next_irq_ctrl;
  logic [WD_TIMEOUT_W-1:0] next_wd_timeout_field;
  logic next_wd_permit;
  logic wr_strobe;
  logic wr_wdog;
  logic wd_kick;
  logic rd_active;

  // A write is taken on the release of the write strobe, when address and data are settled
  assign wr_strobe = clk_en_in && we_n_s && !we_n_prev && !ce_n_s;
  assign wr_wdog = wr_strobe && addr_hit(addr_s, ADDR_WDOG_CTRL);
  assign wd_kick = wr_wdog && data_s[WD_KICK_BIT];
  assign rd_active = !ce_n_s && !oe_n_s && we_n_s;

  always_comb begin
    next_osc_cal = osc_cal;
    next_irq_ctrl = irq_ctrl;
    next_wd_timeout_field = wd_timeout_field;
    next_wd_permit = wd_permit;
    next_dq = 8'h00;
    next_dq_oe_n = 1'b1;
    if (wr_strobe && addr_hit(addr_s, ADDR_OSC_CAL)) begin
      next_osc_cal = data_s & 8'hBF;
    end
    if (wr_strobe && addr_hit(addr_s, ADDR_IRQ_CTRL)) begin
      next_irq_ctrl = data_s & IRQ_WRITE_MASK;
    end
    if (wr_wdog) begin
      next_wd_permit = data_s[WD_PERMIT_BIT];
      // Timeout field only moves when the permit bit was clear beforehand
      if (!wd_permit) begin
        next_wd_timeout_field = data_s[WD_TIMEOUT_W-1:0];
      end
    end
    if (rd_active) begin
      next_dq_oe_n = 1'b0;
      if (addr_hit(addr_s, ADDR_OSC_CAL)) begin
        next_dq = osc_cal;
      end else if (addr_hit(addr_s, ADDR_WDOG_CTRL)) begin
        next_dq = {1'b0, wd_permit, wd_timeout_field};
      end else if (addr_hit(addr_s, ADDR_IRQ_CTRL)) begin
        next_dq = irq_ctrl & ~IRQ_RSVD_MASK;
      end else begin
        next_dq_oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      we_n_prev <= 1'b1;
      pfail_prev <= 1'b0;
      osc_cal <= CAL_RESET;
      irq_ctrl <= IRQ_RESET;
      wd_timeout_field <= WD_TIMEOUT_RESET;
      wd_permit <= WD_PERMIT_RESET;
      dq_out <= 8'h00;
      dq_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      we_n_prev <= we_n_s;
      pfail_prev <= pfail_s;
      osc_cal <= next_osc_cal;
      irq_ctrl <= next_irq_ctrl;
      wd_timeout_field <= next_wd_timeout_field;
      wd_permit <= next_wd_permit;
      dq_out <= next_dq;
      dq_oe_n_out <= next_dq_oe_n;
    end
  end

  assign oscillator_stop_bit_out = osc_cal[CAL_OSC_STOP_BIT];
  assign calibration_out = osc_cal[CAL_FIELD_W-1:0];

  // ----------------------------------------------------------------
  // Watchdog time base and counter
  // ----------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic [WD_TIMEOUT_W-1:0] wd_cnt;
  logic [TICK_CNT_W-1:0] next_tick_cnt;
  logic [WD_TIMEOUT_W-1:0] next_wd_cnt;
  logic osc_run;
  logic tick;
  logic wd_expire;

  // The time base stands still while the oscillator is stopped, so the watchdog does too
  assign osc_run = clk_en_in && !osc_cal[CAL_OSC_STOP_BIT];
  assign tick = osc_run && (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1));
  // A zero timeout field disables the watchdog
  assign wd_expire = tick && (wd_timeout_field != 6'h00) &&
                     (wd_cnt == 6'(wd_timeout_field - 6'h01));

  always_comb begin
    next_tick_cnt = tick_cnt;
    next_wd_cnt = wd_cnt;
    if (osc_run) begin
      next_tick_cnt = tick ? '0 : TICK_CNT_W'(tick_cnt + 1'b1);
    end
    // Restarting the time base with the count makes the span exactly field times one tick
    if (wr_wdog) begin
      next_tick_cnt = '0;
    end
    if (wd_kick || wr_wdog || wd_expire || (wd_timeout_field == 6'h00)) begin
      next_wd_cnt = 6'h00;
    end else if (tick) begin
      next_wd_cnt = 6'(wd_cnt + 6'h01);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tick_cnt <= '0;
      wd_cnt <= 6'h00;
    end else if (clk_en_in) begin
      tick_cnt <= next_tick_cnt;
      wd_cnt <= next_wd_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Event flags and interrupt pin
  // ----------------------------------------------------------------
  logic [2:0] flags;
  logic [2:0] next_flags;
  logic [2:0] flag_set;
  logic [2:0] irq_enables;
  logic irq_level;

  assign flag_set[FLAG_WDOG] = wd_expire;
  assign flag_set[FLAG_ALARM] = clk_en_in && alarm_match_in;
  assign flag_set[FLAG_PFAIL] = clk_en_in && pfail_s && !pfail_prev;
  assign irq_enables = {irq_ctrl[IRQ_PFE_BIT], irq_ctrl[IRQ_AIE_BIT], irq_ctrl[IRQ_WIE_BIT]};

  // A set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    next_flags = (flags & ~flag_clear_in) | flag_set;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flags <= 3'h0;
    end else if (clk_en_in) begin
      flags <= next_flags;
    end
  end

  assign irq_level = |(flags & irq_enables);
  assign watchdog_flag_out = flags[FLAG_WDOG];
  assign alarm_flag_out = flags[FLAG_ALARM];
  assign power_fail_flag_out = flags[FLAG_PFAIL];
  // Active-high mode drives both levels; open-drain mode only ever pulls low
  assign irq_out = irq_ctrl[IRQ_HL_BIT] ? irq_level : 1'b0;
  assign irq_oe_n_out = irq_ctrl[IRQ_HL_BIT] ? 1'b0 : !irq_level;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_wdog_flag_set:
    assert property (wd_expire |=> watchdog_flag_out) else $error("watchdog timeout did not set flag");
  a_wdog_irq_gate:
    assert property ($rose(watchdog_flag_out) && irq_ctrl[IRQ_WIE_BIT] && irq_ctrl[IRQ_HL_BIT] |-> irq_out)
      else $error("enabled watchdog flag did not raise interrupt");
  a_alarm_flag_set:
    assert property (clk_en_in && alarm_match_in |=> alarm_flag_out) else $error("alarm match lost");
  a_pfail_flag_set:
    assert property (clk_en_in && pfail_s && !pfail_prev |=> power_fail_flag_out)
      else $error("power fail trip lost");
  a_irq_masked_quiet:
    assert property (irq_enables == 3'h0 |-> irq_oe_n_out == !irq_ctrl[IRQ_HL_BIT] && !irq_out)
      else $error("interrupt driven with all enables off");
  a_rsvd_read_zero:
    assert property (clk_en_in && rd_active && addr_hit(addr_s, ADDR_IRQ_CTRL) |=> (dq_out & IRQ_RSVD_MASK) == 8'h00)
      else $error("reserved bits read nonzero");
  a_timeout_span:
    assert property ($rose(watchdog_flag_out) && $past(wd_timeout_field) != 6'h00 |->
                     $past(wd_cnt) == 6'($past(wd_timeout_field) - 6'h01) && $past(tick_cnt) == TICK_CNT_W'(TICK_CYCLES - 1))
      else $error("watchdog expired at wrong count");
  a_open_drain_low:
    assert property (!irq_ctrl[IRQ_HL_BIT] |-> !irq_out && (irq_oe_n_out == !irq_level))
      else $error("open drain mode drove high");
  a_kick_restart:
    assert property (wd_kick |=> wd_cnt == 6'h00) else $error("kick did not restart watchdog");

  c_wdog_expire: cover property (wd_expire && irq_ctrl[IRQ_WIE_BIT]);
  c_set_clear_same: cover property (|(flag_set & flag_clear_in));
  c_open_drain_active: cover property (!irq_ctrl[IRQ_HL_BIT] && !irq_oe_n_out);

endmodule

`default_nettype wire

// ---- tb/rwi_host.sv ----
`timescale 1ns/100ps
`default_nettype none

module rwi_host
  import rwi_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [DATA_W-1:0] dev_dq_in,
  input wire logic dev_oe_n_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out
);
  logic drive = 1'b0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic [DATA_W-1:0] last = 8'h00;

  // Released bus toggles each cycle so a stale value never reads as valid
  assign dq_out = drive ? wdata : (!dev_oe_n_in ? dev_dq_in : ~last);
  always @(posedge core_clk_in) begin
    last <= dq_out;
  end

  initial begin
    addr_out = '0;
    ce_n_out = 1'b1;
    we_n_out = 1'b1;
    oe_n_out = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus cycles, launched on the falling edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge core_clk_in);
    addr_out = a;
    wdata = d;
    drive = 1'b1;
    ce_n_out = 1'b0;
    we_n_out = 1'b0;
    repeat (4) @(negedge core_clk_in);
    we_n_out = 1'b1;
    repeat (2) @(negedge core_clk_in);
    ce_n_out = 1'b1;
    drive = 1'b0;
    repeat (3) @(negedge core_clk_in);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(negedge core_clk_in);
    addr_out = a;
    ce_n_out = 1'b0;
    oe_n_out = 1'b0;
    repeat (5) @(negedge core_clk_in);
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
  endtask

  // Keeps the stored timeout since the permit bit is already set
  task automatic kick();
    wr(ADDR_WDOG_CTRL, 8'hC0);
  endtask
endmodule

`default_nettype wire

// ---- tb/rtc_watchdog_interrupt_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module rtc_watchdog_interrupt_control_tb
  import rwi_pkg::*;
;
  logic core_clk, rst, alarm, pfail, clk_en;
  logic prev_oe = 1'b1;
  logic [2:0] fclr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq, dq_o;
  logic ce_n, we_n, oe_n, dq_oe_n, watchdog_flag, af, pff, irq, irq_oe_n, osc;
  logic [CAL_FIELD_W-1:0] cal;
  logic [7:0] expq[$];
  int error_cnt = 0;
  int cmp_count = 0;

  rwi_ctrl u_dut (.core_clk_in(core_clk), .rst_in(rst), .clk_en_in(clk_en), .addr_in(addr),
    .dq_in(dq), .dq_out(dq_o), .dq_oe_n_out(dq_oe_n), .chip_en_n_in(ce_n),
    .write_en_n_in(we_n), .output_en_n_in(oe_n), .alarm_match_in(alarm),
    .power_fail_in(pfail), .flag_clear_in(fclr), .watchdog_flag_out(watchdog_flag),
    .alarm_flag_out(af), .power_fail_flag_out(pff), .irq_out(irq),
    .irq_oe_n_out(irq_oe_n), .oscillator_stop_bit_out(osc), .calibration_out(cal));

  rwi_host u_host (.core_clk_in(core_clk), .dev_dq_in(dq_o), .dev_oe_n_in(dq_oe_n),
    .addr_out(addr), .dq_out(dq), .ce_n_out(ce_n), .we_n_out(we_n), .oe_n_out(oe_n));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Compare tasks and result monitor
  // ----------------------------------------------------------------
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch read data expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask

  always @(negedge core_clk) begin
    prev_oe <= dq_oe_n;
    if (prev_oe === 1'b1 && dq_oe_n === 1'b0) begin
      if (expq.size() == 0) begin
        chk_bit("unexpected read drive", 1'b1, dq_oe_n);
      end else begin
        chk_rd(expq.pop_front(), dq_o);
      end
    end
  end

  task automatic rdx(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_host.rd(a);
  endtask

  // Pull-up on the pin when nobody drives it
  task automatic pin(input logic hl, input logic act);
    chk_bit("irq pin", hl ? act : !act, irq_oe_n ? 1'b1 : irq);
  endtask

  task automatic clear(input logic [2:0] m, input logic hl);
    @(negedge core_clk) fclr = m;
    @(negedge core_clk) fclr = 3'h0;
    @(negedge core_clk);
    chk_bit("flags cleared", 1'b0, af | pff);
    pin(hl, 1'b0);
  endtask

  task automatic results();
    if (expq.size() != 0) error_cnt++;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] r;
    logic hl, en;
    rst = 1'b1;
    alarm = 1'b0;
    pfail = 1'b0;
    fclr = 3'h0;
    clk_en = 1'b1;
    void'($urandom(32'hE56F));
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    rdx(ADDR_IRQ_CTRL, IRQ_RESET);
    u_host.wr(ADDR_IRQ_CTRL, 8'hEC);
    rdx(ADDR_IRQ_CTRL, 8'hEC);
    u_host.wr(ADDR_WDOG_CTRL, 8'hC5);
    rdx(ADDR_WDOG_CTRL, 8'h45);
    u_host.kick();
    rdx(ADDR_WDOG_CTRL, 8'h45);
    u_host.wr(ADDR_WDOG_CTRL, 8'h3F);
    rdx(ADDR_WDOG_CTRL, 8'h05);
    r = 8'($urandom());
    u_host.wr(ADDR_OSC_CAL, r);
    rdx(ADDR_OSC_CAL, r & 8'hBF);
    chk_bit("osc stop", r[7], osc);
    chk_bit("cal sign", r[5], cal[5]);
    u_host.rd(19'h7FFF5);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      hl = i[1];
      en = i[0];
      u_host.wr(ADDR_IRQ_CTRL, {en, en, en, 1'b0, hl, 3'b000});
      @(negedge core_clk) alarm = 1'b1;
      @(negedge core_clk) alarm = 1'b0;
      @(negedge core_clk);
      chk_bit("alarm flag", 1'b1, af);
      pin(hl, en);
      if (i == 0) begin
        clk_en = 1'b0;
        fclr = 3'h2;
        @(negedge core_clk) chk_bit("frozen alarm flag", 1'b1, af);
        clk_en = 1'b1;
        alarm = 1'b1;
        @(negedge core_clk) {alarm, fclr} = 4'h0;
        @(negedge core_clk);
        chk_bit("alarm set beats clear", 1'b1, af);
      end
      clear(3'h2, hl);
      pfail = 1'b1;
      repeat (5) @(negedge core_clk);
      chk_bit("power fail flag", 1'b1, pff);
      pin(hl, en);
      pfail = 1'b0;
      clear(3'h4, hl);
      $display("test events %0d done", i);
    end
    // A five-tick timeout lies far beyond this run, so the flag stays low
    chk_bit("watchdog flag", 1'b0, watchdog_flag);
    results();
  end
endmodule

`default_nettype wire
